// file: pac_pkg.sv
// Constants and types for the parameter-access command handler
// Contract
// - Code 5 writes value into axis parameter selected by type, axis 0.
// - Code 6 returns selected axis parameter with status 100.
// - Standalone axis reads also load accumulator; direct mode leaves it alone.
// - Code 7 stores axis parameter to non-volatile copy, replies 100, 0.
// - Code 8 reloads axis parameter from non-volatile copy, ignores value.
// - After power up all axis parameters load from non-volatile copy.
// - Code 9 writes value into global parameter of bank 0, 2 or 3.
// - Bank 0 module settings, bank 2 user variables, bank 3 interrupts.
// - Writes to bank 0 settings also commit to non-volatile memory.
// - Code 10 reads global parameter, loads accumulator, replies 100.
// - Store-global saves bank 2 variable; power on restores user variables.
// - Set and store commands reply status 100 with don't-care value.
// - Axis values set by code 5 stay volatile until stored.
// - Code 11 commits selected global parameter to non-volatile memory.
// - Code 12 reloads selected user variable from non-volatile copy.
package pac_pkg;
	localparam int PAC_FRAME_LEN = 9;
	localparam logic [3:0] PAC_IDX_ADDR = 4'h0;
	localparam logic [3:0] PAC_IDX_CODE = 4'h1;
	localparam logic [3:0] PAC_IDX_TYPE = 4'h2;
	localparam logic [3:0] PAC_IDX_BANK = 4'h3;
	localparam logic [3:0] PAC_IDX_CSUM = 4'h8;
	localparam logic [7:0] PAC_SET_AXIS_PARAM = 8'h05;
	localparam logic [7:0] PAC_GET_AXIS_PARAM = 8'h06;
	localparam logic [7:0] PAC_STORE_AXIS_PARAM = 8'h07;
	localparam logic [7:0] PAC_RESTORE_AXIS_PARAM = 8'h08;
	localparam logic [7:0] PAC_SET_GLOBAL_PARAM = 8'h09;
	localparam logic [7:0] PAC_GET_GLOBAL_PARAM = 8'h0A;
	localparam logic [7:0] PAC_STORE_GLOBAL_PARAM = 8'h0B;
	localparam logic [7:0] PAC_RESTORE_GLOBAL_PARAM = 8'h0C;
	localparam logic [7:0] PAC_BANK_MODULE = 8'h00;
	localparam logic [7:0] PAC_BANK_USER = 8'h02;
	localparam logic [7:0] PAC_BANK_IRQ = 8'h03;
	localparam logic [7:0] PAC_AXIS0 = 8'h00;
	localparam logic [7:0] PAC_ST_OK = 8'h64;
	localparam logic [7:0] PAC_ST_BAD_CMD = 8'h02;
	localparam logic [7:0] PAC_ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] PAC_ST_BAD_VAL = 8'h04;
	localparam logic [31:0] PAC_ZERO = 32'h0000_0000;
	localparam logic [1:0] PAC_BSEL_MODULE = 2'h0;
	localparam logic [1:0] PAC_BSEL_USER = 2'h1;
	localparam logic [1:0] PAC_BSEL_IRQ = 2'h2;

	typedef enum logic [6:0] {
		PAC_INIT = 7'b000_0001,
		PAC_RECV = 7'b000_0010,
		PAC_CHECK = 7'b000_0100,
		PAC_EXEC = 7'b000_1000,
		PAC_NVWAIT = 7'b001_0000,
		PAC_LOAD = 7'b010_0000,
		PAC_SEND = 7'b100_0000
	} pac_state_e;

	function automatic logic [7:0] pac_sum8(input logic [7:0] a,
		input logic [7:0] b);
		pac_sum8 = 8'(a + b);
	endfunction
endpackage

// file: pac_nv_store.sv
// Non-volatile backing store model with one-cycle latency
`timescale 1ns/1ps
module pac_nv_store import pac_pkg::*; #(
	parameter int ADDR_W = 10
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wr_data,
	output logic [31:0] rd_data,
	output logic done
);
	logic [31:0] mem [0:(1<<ADDR_W)-1];

	initial begin
		if (ADDR_W < 2 || ADDR_W > 16) begin
			$error("ADDR_W out of range");
		end
	end

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= PAC_ZERO;
			done <= 1'b0;
		end else begin
			rd_data <= mem[addr];
			done <= wr_en | rd_en;
		end
	end
endmodule

// file: pac_handler.sv
// Command frame decoder and parameter-access engine
`timescale 1ns/1ps
module pac_handler import pac_pkg::*; #(
	parameter int AXIS_N = 256,
	parameter int GLOB_N = 256,
	parameter logic [7:0] HOST_ADDR = 8'h02,
	parameter logic [7:0] MODULE_ADDR = 8'h01
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic standalone,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_valid,
	output logic busy,
	output logic [31:0] accu,
	output logic frame_error
);
	localparam int NV_W = 10;
	localparam logic [9:0] NV_AXIS_BASE = 10'h000;
	localparam logic [9:0] NV_MOD_BASE = 10'h100;
	localparam logic [9:0] NV_USER_BASE = 10'h200;
	localparam logic [8:0] INIT_LAST = 9'h1FF;

	initial begin
		if (AXIS_N != 256 || GLOB_N != 256) begin
			$error("parameter tables must hold 256 entries");
		end
	end

	pac_state_e state_r;
	logic [7:0] frame_r [0:PAC_FRAME_LEN-1];
	logic [3:0] rx_cnt_r;
	logic [7:0] sum_r;
	logic [31:0] axis_r [0:AXIS_N-1];
	logic [31:0] mod_r [0:GLOB_N-1];
	logic [31:0] user_r [0:GLOB_N-1];
	logic [31:0] irq_r [0:GLOB_N-1];
	logic [8:0] init_cnt_r;
	logic [1:0] ld_bank_r;
	logic [7:0] ld_idx_r;
	logic [7:0] rep_status_r;
	logic [31:0] rep_value_r;
	logic [7:0] tx_frame_r [0:PAC_FRAME_LEN-1];
	logic [3:0] tx_cnt_r;
	logic nv_wr;
	logic nv_rd;
	logic [NV_W-1:0] nv_addr;
	logic [31:0] nv_wdata;
	logic [31:0] nv_rdata;
	logic nv_done;

	logic [7:0] code;
	logic [7:0] ptype;
	logic [7:0] bank;
	logic [31:0] value;
	assign code = frame_r[PAC_IDX_CODE];
	assign ptype = frame_r[PAC_IDX_TYPE];
	assign bank = frame_r[PAC_IDX_BANK];
	assign value = {frame_r[4], frame_r[5], frame_r[6], frame_r[7]};

	function automatic logic bank_ok(input logic [7:0] b);
		bank_ok = (b == PAC_BANK_MODULE) || (b == PAC_BANK_USER) ||
			(b == PAC_BANK_IRQ);
	endfunction

	function automatic logic [31:0] glob_rd(input logic [7:0] b,
		input logic [7:0] t);
		case (b)
			PAC_BANK_MODULE: glob_rd = mod_r[t];
			PAC_BANK_USER: glob_rd = user_r[t];
			default: glob_rd = irq_r[t];
		endcase
	endfunction

	// Non-volatile request decode, combinational from state and frame
	always_comb begin
		nv_wr = 1'b0;
		nv_rd = 1'b0;
		nv_addr = {NV_AXIS_BASE[NV_W-1:8], init_cnt_r[7:0]};
		nv_wdata = PAC_ZERO;
		if (state_r == PAC_INIT) begin
			nv_rd = 1'b1;
			nv_addr = init_cnt_r[8] ? {NV_USER_BASE[NV_W-1:8],
				init_cnt_r[7:0]} : {NV_AXIS_BASE[NV_W-1:8],
				init_cnt_r[7:0]};
		end else if (state_r == PAC_EXEC && !frame_error) begin
			case (code)
				PAC_STORE_AXIS_PARAM: begin
					nv_wr = 1'b1;
					nv_addr = {NV_AXIS_BASE[NV_W-1:8], ptype};
					nv_wdata = axis_r[ptype];
				end
				PAC_RESTORE_AXIS_PARAM: begin
					nv_rd = 1'b1;
					nv_addr = {NV_AXIS_BASE[NV_W-1:8], ptype};
				end
				PAC_SET_GLOBAL_PARAM: begin
					nv_wr = (bank == PAC_BANK_MODULE);
					nv_addr = {NV_MOD_BASE[NV_W-1:8], ptype};
					nv_wdata = value;
				end
				PAC_STORE_GLOBAL_PARAM: begin
					nv_wr = 1'b1;
					nv_addr = (bank == PAC_BANK_USER) ?
						{NV_USER_BASE[NV_W-1:8], ptype} :
						{NV_MOD_BASE[NV_W-1:8], ptype};
					nv_wdata = glob_rd(bank, ptype);
				end
				PAC_RESTORE_GLOBAL_PARAM: begin
					nv_rd = 1'b1;
					nv_addr = {NV_USER_BASE[NV_W-1:8], ptype};
				end
				default: begin
					nv_wr = 1'b0;
				end
			endcase
		end
	end

	pac_nv_store #(.ADDR_W(NV_W)) u_nv (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.wr_en(nv_wr),
		.rd_en(nv_rd),
		.addr(nv_addr),
		.wr_data(nv_wdata),
		.rd_data(nv_rdata),
		.done(nv_done)
	);

	// Sequencer
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= PAC_INIT;
		end else begin
			case (state_r)
				PAC_INIT: if (init_cnt_r == INIT_LAST) state_r <= PAC_RECV;
				PAC_RECV: if (rx_valid && rx_cnt_r == PAC_IDX_CSUM)
					state_r <= PAC_CHECK;
				PAC_CHECK: state_r <= PAC_EXEC;
				PAC_EXEC: state_r <= (frame_error) ? PAC_RECV :
					(nv_wr || nv_rd) ? PAC_NVWAIT : PAC_LOAD;
				PAC_NVWAIT: if (nv_done) state_r <= PAC_LOAD;
				PAC_LOAD: state_r <= PAC_SEND;
				PAC_SEND: if (tx_ready && tx_cnt_r == PAC_IDX_CSUM)
					state_r <= PAC_RECV;
				default: state_r <= PAC_INIT;
			endcase
		end
	end

	// Power-up load counter, read only; loaded words go into the tables below
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			init_cnt_r <= 9'h000;
		end else if (state_r == PAC_INIT) begin
			init_cnt_r <= 9'(init_cnt_r + 9'h001);
		end
	end

	// Receive path and running checksum
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_cnt_r <= 4'h0;
			sum_r <= 8'h00;
		end else if (state_r == PAC_RECV && rx_valid) begin
			if (rx_cnt_r == PAC_IDX_CSUM) begin
				rx_cnt_r <= 4'h0;
			end else begin
				rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
				sum_r <= (rx_cnt_r == PAC_IDX_ADDR) ? rx_data :
					pac_sum8(sum_r, rx_data);
			end
		end
	end

	// Frame byte store, needs no reset
	always_ff @(posedge core_clk) begin
		if (state_r == PAC_RECV && rx_valid) begin
			frame_r[rx_cnt_r] <= rx_data;
		end
	end

	// Address and checksum qualification
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_error <= 1'b0;
		end else if (state_r == PAC_CHECK) begin
			frame_error <= (frame_r[PAC_IDX_ADDR] != MODULE_ADDR) ||
				(frame_r[PAC_IDX_CSUM] != sum_r);
		end
	end

	// Delayed load target for non-volatile reads
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ld_bank_r <= PAC_BSEL_MODULE;
			ld_idx_r <= 8'h00;
		end else if (nv_rd) begin
			ld_bank_r <= (state_r == PAC_INIT) ?
				(init_cnt_r[8] ? PAC_BSEL_USER : PAC_BSEL_IRQ) :
				((code == PAC_RESTORE_GLOBAL_PARAM) ? PAC_BSEL_USER :
				PAC_BSEL_IRQ);
			ld_idx_r <= (state_r == PAC_INIT) ? init_cnt_r[7:0] : ptype;
		end else if (nv_wr) begin
			// Write completions must not load a table
			ld_bank_r <= PAC_BSEL_MODULE;
		end
	end

	// Parameter tables; axis table is volatile working storage
	always_ff @(posedge core_clk) begin
		if (nv_done && ld_bank_r == PAC_BSEL_IRQ) begin
			axis_r[ld_idx_r] <= nv_rdata;
		end else if (nv_done && ld_bank_r == PAC_BSEL_USER) begin
			user_r[ld_idx_r] <= nv_rdata;
		end else if (state_r == PAC_EXEC && !frame_error) begin
			if (code == PAC_SET_AXIS_PARAM && bank == PAC_AXIS0) begin
				axis_r[ptype] <= value;
			end
			if (code == PAC_SET_GLOBAL_PARAM) begin
				case (bank)
					PAC_BANK_MODULE: mod_r[ptype] <= value;
					PAC_BANK_USER: user_r[ptype] <= value;
					PAC_BANK_IRQ: irq_r[ptype] <= value;
					default: ;
				endcase
			end
		end
	end

	// Reply status, value and accumulator
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rep_status_r <= PAC_ST_OK;
			rep_value_r <= PAC_ZERO;
			accu <= PAC_ZERO;
		end else if (state_r == PAC_EXEC && !frame_error) begin
			rep_status_r <= PAC_ST_OK;
			rep_value_r <= PAC_ZERO;
			case (code)
				PAC_SET_AXIS_PARAM, PAC_STORE_AXIS_PARAM,
				PAC_RESTORE_AXIS_PARAM: begin
					if (bank != PAC_AXIS0) rep_status_r <= PAC_ST_BAD_VAL;
				end
				PAC_GET_AXIS_PARAM: begin
					if (bank != PAC_AXIS0) begin
						rep_status_r <= PAC_ST_BAD_VAL;
					end else begin
						rep_value_r <= axis_r[ptype];
						if (standalone) accu <= axis_r[ptype];
					end
				end
				PAC_SET_GLOBAL_PARAM, PAC_GET_GLOBAL_PARAM: begin
					if (!bank_ok(bank)) begin
						rep_status_r <= PAC_ST_BAD_VAL;
					end else if (code == PAC_GET_GLOBAL_PARAM) begin
						rep_value_r <= glob_rd(bank, ptype);
						accu <= glob_rd(bank, ptype);
					end
				end
				PAC_STORE_GLOBAL_PARAM,
				PAC_RESTORE_GLOBAL_PARAM: begin
					if (bank != PAC_BANK_USER &&
						code == PAC_RESTORE_GLOBAL_PARAM)
						rep_status_r <= PAC_ST_BAD_TYPE;
				end
				default: rep_status_r <= PAC_ST_BAD_CMD;
			endcase
		end
	end

	// Reply frame image, taken once the reply fields are final
	always_ff @(posedge core_clk) begin
		if (state_r == PAC_LOAD) begin
			tx_frame_r[0] <= HOST_ADDR;
			tx_frame_r[1] <= MODULE_ADDR;
			tx_frame_r[2] <= rep_status_r;
			tx_frame_r[3] <= code;
			tx_frame_r[4] <= rep_value_r[31:24];
			tx_frame_r[5] <= rep_value_r[23:16];
			tx_frame_r[6] <= rep_value_r[15:8];
			tx_frame_r[7] <= rep_value_r[7:0];
			tx_frame_r[8] <= 8'(HOST_ADDR + MODULE_ADDR + rep_status_r +
				code + rep_value_r[31:24] + rep_value_r[23:16] +
				rep_value_r[15:8] + rep_value_r[7:0]);
		end
	end

	// Reply framing and byte transmit
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_cnt_r <= 4'h0;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			busy <= 1'b1;
		end else begin
			busy <= (state_r != PAC_RECV);
			if (state_r == PAC_LOAD) begin
				tx_cnt_r <= 4'h0;
				tx_valid <= 1'b0;
			end else if (state_r == PAC_SEND) begin
				tx_valid <= 1'b1;
				tx_data <= tx_frame_r[tx_cnt_r];
				if (tx_valid && tx_ready) begin
					if (tx_cnt_r == PAC_IDX_CSUM) begin
						tx_valid <= 1'b0;
					end else begin
						tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
						tx_data <= tx_frame_r[4'(tx_cnt_r + 4'h1)];
					end
				end
			end else begin
				tx_valid <= 1'b0;
			end
		end
	end
endmodule

// file: pac_handler_chk.sv
// Assertion checker for the parameter-access command handler
`timescale 1ns/1ps
module pac_handler_chk import pac_pkg::*; #(
	parameter logic [7:0] HOST_ADDR = 8'h02,
	parameter logic [7:0] MODULE_ADDR = 8'h01
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic standalone,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic busy,
	input wire logic [31:0] accu,
	input wire logic frame_error
);
	logic [3:0] idx_r;
	logic [7:0] sum_r;
	wire logic hs = tx_valid && tx_ready;
	// Reply byte position
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			idx_r <= 4'h0;
		else if (hs)
			idx_r <= (idx_r == 4'h8) ? 4'h0 : idx_r + 4'h1;
	end
	// Running sum of reply bytes
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			sum_r <= 8'h00;
		else if (hs)
			sum_r <= (idx_r == 4'h8) ? 8'h00 : 8'(sum_r + tx_data);
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_close;
		!tx_valid ##1 !busy;
	endsequence
	chk_load_busy: assert property ($rose(reset_n) |-> busy [*8])
		else $error("busy low during power-up load");
	chk_reply_hold: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable(tx_data))
		else $error("reply byte not held");
	chk_reply_busy: assert property (tx_valid |-> busy)
		else $error("reply offered while idle");
	chk_accu_idle: assert property (!busy ##1 !busy |-> $stable(accu))
		else $error("accumulator moved while idle");
	chk_host_byte: assert property (tx_valid && idx_r == 4'h0
		|-> tx_data == HOST_ADDR)
		else $error("first reply byte wrong");
	chk_own_byte: assert property (tx_valid && idx_r == 4'h1
		|-> tx_data == MODULE_ADDR)
		else $error("second reply byte wrong");
	chk_reply_sum: assert property (tx_valid && idx_r == 4'h8
		|-> tx_data == sum_r)
		else $error("reply checksum wrong");
	chk_reply_end: assert property (hs && idx_r == 4'h8 |=> s_close)
		else $error("reply did not close");
endmodule
bind pac_handler pac_handler_chk #(.HOST_ADDR(HOST_ADDR),
	.MODULE_ADDR(MODULE_ADDR)) u_chk (.core_clk(core_clk),
	.reset_n(reset_n), .rx_data(rx_data), .rx_valid(rx_valid),
	.standalone(standalone), .tx_ready(tx_ready), .tx_data(tx_data),
	.tx_valid(tx_valid), .busy(busy), .accu(accu),
	.frame_error(frame_error));

// file: pac_host.sv
// Host model that sends command frames and collects replies
`timescale 1ns/1ps
module pac_host (
	input wire logic core_clk,
	input wire logic busy,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic tx_ready
);
	logic [7:0] rep [9];
	int n;
	bit tmo;
	bit stall;
	initial begin
		rx_data = 8'h5A;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
		stall = 1'b0;
	end
	task automatic send(input logic [7:0] adr, code, typ, bnk,
		input logic [31:0] v, input logic bad);
		logic [7:0] f [9];
		int k;
		f = '{adr, code, typ, bnk, v[31:24], v[23:16], v[15:8], v[7:0],
			8'h00};
		for (k = 0; k < 8; k++)
			f[8] = 8'(f[8] + f[k]);
		f[8] = 8'(f[8] + {7'h00, bad});
		n = 0;
		tmo = 0;
		for (k = 0; k < 700 && busy; k++) begin
			@(posedge core_clk);
			#1;
		end
		tmo = busy;
		if (tmo)
			return;
		for (k = 0; k < 9; k++) begin
			rx_data = f[k];
			rx_valid = 1'b1;
			@(posedge core_clk);
			#1;
		end
		rx_valid = 1'b0;
		rx_data = ~f[8];
		for (k = 0; k < 80; k++) begin
			tx_ready = stall ? k[0] : 1'b1;
			@(posedge core_clk);
			if (tx_valid && tx_ready && n < 9) begin
				rep[n] = tx_data;
				n++;
			end
			#1;
			if (k > 3 && !busy)
				break;
		end
		tx_ready = 1'b0;
		tmo = (k == 80);
	endtask
endmodule

// file: pac_handler_tb.sv
// Self-checking testbench for the parameter-access command handler
`timescale 1ns/1ps
module pac_handler_tb import pac_pkg::*; ;
	logic core_clk, reset_n, rx_valid, standalone, tx_ready;
	logic tx_valid, busy, frame_error;
	logic [7:0] rx_data, tx_data;
	logic [31:0] accu, a;
	int mismatches, comparisons;
	pac_handler u_pac_handler (.core_clk(core_clk), .reset_n(reset_n),
		.rx_data(rx_data), .rx_valid(rx_valid), .standalone(standalone),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.busy(busy), .accu(accu), .frame_error(frame_error));
	pac_host u_pac_host (.core_clk(core_clk), .busy(busy),
		.tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data),
		.rx_valid(rx_valid), .tx_ready(tx_ready));
	always #10 core_clk = ~core_clk;
	task finish_test;
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	function logic [31:0] rval;
		return {u_pac_host.rep[4], u_pac_host.rep[5], u_pac_host.rep[6],
			u_pac_host.rep[7]};
	endfunction
	task snd(input logic [7:0] adr, code, typ, bnk, input logic [31:0] v,
		input logic bad);
		u_pac_host.send(adr, code, typ, bnk, v, bad);
		if (u_pac_host.tmo) begin
			mismatches++;
			finish_test;
		end
	endtask
	task cmd(input logic [7:0] code, typ, bnk, input logic [31:0] v);
		snd(8'h01, code, typ, bnk, v, 1'b0);
		chk(u_pac_host.n, 9);
		chk(u_pac_host.rep[2], PAC_ST_OK);
		chk(u_pac_host.rep[3], code);
	endtask
	task t_axis;
		cmd(PAC_SET_AXIS_PARAM, 8'h04, 8'h00, 32'h0000_C800);
		a = accu;
		cmd(PAC_GET_AXIS_PARAM, 8'h04, 8'h00, 32'h0000_0000);
		chk(rval(), 32'h0000_C800);
		chk(accu, a);
		standalone = 1'b1;
		cmd(PAC_GET_AXIS_PARAM, 8'h04, 8'h00, 32'h0000_0000);
		chk(accu, 32'h0000_C800);
		standalone = 1'b0;
	endtask
	task t_store;
		u_pac_host.stall = 1'b1;
		cmd(PAC_SET_AXIS_PARAM, 8'h06, 8'h00, 32'h1234_5678);
		cmd(PAC_STORE_AXIS_PARAM, 8'h06, 8'h00, 32'hFFFF_FFFF);
		chk(rval(), 32'h0000_0000);
		cmd(PAC_SET_AXIS_PARAM, 8'h06, 8'h00, 32'h0000_5555);
		cmd(PAC_RESTORE_AXIS_PARAM, 8'h06, 8'h00, 32'hFFFF_FFFF);
		cmd(PAC_GET_AXIS_PARAM, 8'h06, 8'h00, 32'h0000_0000);
		chk(rval(), 32'h1234_5678);
		u_pac_host.stall = 1'b0;
	endtask
	task t_global;
		logic [7:0] b [3];
		b = '{PAC_BANK_MODULE, PAC_BANK_USER, PAC_BANK_IRQ};
		foreach (b[i]) begin
			cmd(PAC_SET_GLOBAL_PARAM, 8'h2A, b[i], {24'hA0_0000, b[i]});
			cmd(PAC_GET_GLOBAL_PARAM, 8'h2A, b[i], 32'h0000_0000);
			chk(rval(), {24'hA0_0000, b[i]});
			chk(accu, {24'hA0_0000, b[i]});
		end
		cmd(PAC_STORE_GLOBAL_PARAM, 8'h2A, PAC_BANK_USER, PAC_ZERO);
		cmd(PAC_SET_GLOBAL_PARAM, 8'h2A, PAC_BANK_USER, 32'h0000_0001);
		cmd(PAC_RESTORE_GLOBAL_PARAM, 8'h2A, PAC_BANK_USER, PAC_ZERO);
		cmd(PAC_GET_GLOBAL_PARAM, 8'h2A, PAC_BANK_USER, PAC_ZERO);
		chk(rval(), 32'hA000_0002);
	endtask
	task t_status;
		snd(8'h01, PAC_GET_AXIS_PARAM, 8'h04, 8'h01, PAC_ZERO, 1'b0);
		chk(u_pac_host.n, 9);
		chk(u_pac_host.rep[2], PAC_ST_BAD_VAL);
		snd(8'h01, PAC_GET_GLOBAL_PARAM, 8'h2A, 8'h01, PAC_ZERO, 1'b0);
		chk(u_pac_host.rep[2], PAC_ST_BAD_VAL);
		snd(8'h01, PAC_RESTORE_GLOBAL_PARAM, 8'h2A, 8'h00, PAC_ZERO, 1'b0);
		chk(u_pac_host.rep[2], PAC_ST_BAD_TYPE);
		snd(8'h01, 8'h01, 8'h00, 8'h00, PAC_ZERO, 1'b0);
		chk(u_pac_host.rep[2], PAC_ST_BAD_CMD);
		chk(u_pac_host.rep[3], 8'h01);
	endtask
	task t_bad;
		snd(8'h01, PAC_SET_AXIS_PARAM, 8'h04, 8'h00, 32'h0000_DEAD, 1'b1);
		chk(u_pac_host.n, 0);
		chk(frame_error, 1'b1);
		snd(8'h01, PAC_RESTORE_AXIS_PARAM, 8'h04, 8'h00, PAC_ZERO, 1'b1);
		chk(u_pac_host.n, 0);
		snd(8'h07, PAC_SET_AXIS_PARAM, 8'h04, 8'h00, 32'h0000_DEAD, 1'b0);
		chk(u_pac_host.n, 0);
		cmd(PAC_GET_AXIS_PARAM, 8'h04, 8'h00, 32'h0000_0000);
		chk(rval(), 32'h0000_C800);
		chk(frame_error, 1'b0);
	endtask
	task t_power;
		reset_n = 1'b0;
		repeat (16) @(posedge core_clk);
		#1 reset_n = 1'b1;
		chk(busy, 1'b1);
		cmd(PAC_GET_AXIS_PARAM, 8'h06, 8'h00, 32'h0000_0000);
		chk(rval(), 32'h1234_5678);
		cmd(PAC_GET_GLOBAL_PARAM, 8'h2A, PAC_BANK_USER, PAC_ZERO);
		chk(rval(), 32'hA000_0002);
	endtask
	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		standalone = 1'b0;
		mismatches = 0;
		comparisons = 0;
		repeat (16) @(posedge core_clk);
		#1 reset_n = 1'b1;
		t_axis;
		t_store;
		t_global;
		t_status;
		t_bad;
		t_power;
		finish_test;
	end
endmodule
